// ==== fault_limit_response_unit.sv ====
// Over-temperature supervision with threshold registers behind a management bus slave
//////////////////////////////////////////////////////////////////////////////////////
// Operation
// R1: Overcurrent threshold word register at 0x46.
// R2: Undercurrent threshold word register at 0x4B.
// R3: Over-temperature fault threshold word at 0x4F.
// R4: Over-temperature warning threshold word at 0x51.
// R5: Under-temperature warning threshold word at 0x52.
// R6: Action byte 0x50; any fault alerts, sets status.
// R7: Mode 00 keeps regulating through fault.
// R8: Mode 01 runs for delay, then retries.
// R9: Mode 10 disables at once, then retries.
// R10: Mode 11 disables while fault persists.
// R11: Retry 000 stays off until cleared.
// R12: Retry 1..6 tries that often, then off.
// R13: Attempts spaced by delay field times unit.
// R14: Retry 111 repeats until disabled or shutdown.
// R15: Units are 80 ms run, 32 ms spacing.
// R16: Warning thresholds set status and alert.
// R17: Host uses word and byte transfers.
`include "fault_limit_consts.svh"

module fault_limit_response_unit #(
	parameter logic [6:0] BUS_ADDR = `BUS_ADDR_DEFAULT,
	parameter int unsigned DELAY_UNIT_CYC = `OT_DELAY_UNIT_CYC,
	parameter int unsigned RESTART_UNIT_CYC = `OT_RESTART_UNIT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Management bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Measurement and control
	input wire logic [15:0] temp_value,
	input wire logic enable_request,
	input wire logic other_shutdown,
	input wire logic fault_clear,
	// Results
	output logic output_enable,
	output logic alert_out_n,
	output fault_limit_pkg::status_s status,
	output fault_limit_pkg::limits_s limits
);
	import fault_limit_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus conditions
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_s;
	logic sda_s;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	limits_s lim_q;
	logic [15:0] ot_limit_q;
	logic [15:0] ot_warn_q;
	logic [15:0] ut_warn_q;
	logic [7:0] action_q;
	logic [7:0] cmd_q;
	logic [7:0] data_lo_q;
	logic [7:0] data_hi_q;
	logic [2:0] byte_idx_q;
	logic rw_q;
	logic [15:0] rd_word;
	logic [15:0] wdata;
	logic commit_word;
	logic commit_byte;

	function automatic logic cmd_valid(input logic [7:0] c);
		cmd_valid = (c == `CMD_OC_LIMIT) || (c == `CMD_UC_LIMIT) || (c == `CMD_OT_LIMIT) ||
			(c == `CMD_OT_ACTION) || (c == `CMD_OT_WARN) || (c == `CMD_UT_WARN);
	endfunction

	always_comb
	begin
		case (cmd_q)
			`CMD_OC_LIMIT: rd_word = lim_q.oc;
			`CMD_UC_LIMIT: rd_word = lim_q.uc;
			`CMD_OT_LIMIT: rd_word = ot_limit_q;
			`CMD_OT_ACTION: rd_word = {8'h00, action_q};
			`CMD_OT_WARN: rd_word = ot_warn_q;
			`CMD_UT_WARN: rd_word = ut_warn_q;
			default: rd_word = {`TX_FILL, `TX_FILL};
		endcase
	end

	// Writes land only at stop with the exact length, so a cut-short word never half-updates
	assign wdata = {data_hi_q, data_lo_q};
	assign commit_word = bus_stop && !rw_q && byte_idx_q == `WORD_WR_COUNT &&
		cmd_valid(cmd_q) && cmd_q != `CMD_OT_ACTION;
	assign commit_byte = bus_stop && !rw_q && byte_idx_q == `BYTE_WR_COUNT &&
		cmd_q == `CMD_OT_ACTION;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lim_q.oc <= `RST_OC_LIMIT;
			lim_q.uc <= `RST_UC_LIMIT;
			ot_limit_q <= `RST_OT_LIMIT;
			ot_warn_q <= `RST_OT_WARN;
			ut_warn_q <= `RST_UT_WARN;
			action_q <= `RST_OT_ACTION;
		end
		else if (commit_word)
		begin
			case (cmd_q)
				`CMD_OC_LIMIT: lim_q.oc <= wdata; // see R1
				`CMD_UC_LIMIT: lim_q.uc <= wdata; // see R2
				`CMD_OT_LIMIT: ot_limit_q <= wdata; // see R3
				`CMD_OT_WARN: ot_warn_q <= wdata; // see R4
				`CMD_UT_WARN: ut_warn_q <= wdata; // see R5
				default: ;
			endcase
		end
		else if (commit_byte)
			action_q <= data_lo_q; // see R6
	end

	word_write_a: assert property (commit_word |=> rd_word == $past(wdata)) // see R1 R2 R3 R4 R5
		else $error("word write did not reach register");
	byte_write_a: assert property (commit_byte |=> action_q == $past(data_lo_q)) // see R6
		else $error("action byte write did not reach register");

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave
	bus_e bus_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [2:0] tx_idx_q;
	logic sda_oe_q;
	logic sda_out_q;
	logic [7:0] tx_next;

	assign tx_next = (tx_idx_q == `IDX_CMD && cmd_q != `CMD_OT_ACTION) ? rd_word[15:8] : `TX_FILL;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bus_q <= BUS_IDLE;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= `IDX_ADDR;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			tx_idx_q <= 3'h0;
			rw_q <= 1'b0;
			cmd_q <= `CMD_OC_LIMIT;
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
			sda_oe_q <= 1'b0;
			sda_out_q <= 1'b0;
		end
		else if (bus_stop)
		begin
			bus_q <= BUS_IDLE;
			sda_oe_q <= 1'b0;
			byte_idx_q <= `IDX_ADDR;
		end
		else if (bus_start)
		begin
			bus_q <= BUS_RX;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= `IDX_ADDR;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			case (bus_q)
				BUS_RX:
				begin
					if (scl_rise)
					begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (scl_fall && bit_cnt_q == `BYTE_BITS)
					begin
						bit_cnt_q <= 4'h0;
						bus_q <= BUS_RX_ACK;
						sda_oe_q <= 1'b1;
						if (byte_idx_q != `IDX_MAX)
							byte_idx_q <= byte_idx_q + 3'h1;
						case (byte_idx_q)
							`IDX_ADDR:
							begin
								if (shift_q[7:1] != BUS_ADDR)
								begin
									bus_q <= BUS_IDLE;
									sda_oe_q <= 1'b0;
								end
								else
									rw_q <= shift_q[0];
								tx_idx_q <= 3'h0;
							end
							`IDX_CMD:
							begin
								// Unknown commands are refused with a NACK
								if (cmd_valid(shift_q))
									cmd_q <= shift_q;
								else
								begin
									bus_q <= BUS_IDLE;
									sda_oe_q <= 1'b0;
								end
							end
							`IDX_DATA_LO: data_lo_q <= shift_q;
							`IDX_DATA_HI: data_hi_q <= shift_q;
							default: ;
						endcase
					end
				end
				BUS_RX_ACK:
				begin
					if (scl_fall && rw_q)
					begin
						bus_q <= BUS_TX;
						tx_q <= rd_word[7:0];
						sda_oe_q <= ~rd_word[7];
						tx_idx_q <= `IDX_CMD;
					end
					else if (scl_fall)
					begin
						bus_q <= BUS_RX;
						sda_oe_q <= 1'b0;
					end
				end
				BUS_TX:
				begin
					if (scl_fall && bit_cnt_q == `BYTE_LAST_BIT)
					begin
						bus_q <= BUS_TX_ACK;
						sda_oe_q <= 1'b0;
						bit_cnt_q <= 4'h0;
					end
					else if (scl_fall)
					begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[6];
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				BUS_TX_ACK:
				begin
					if (scl_rise)
						bus_q <= sda_s ? BUS_IDLE : BUS_TX_LOAD;
				end
				BUS_TX_LOAD:
				begin
					if (scl_fall)
					begin
						bus_q <= BUS_TX;
						tx_q <= tx_next;
						sda_oe_q <= ~tx_next[7];
						if (tx_idx_q != `IDX_MAX)
							tx_idx_q <= tx_idx_q + 3'h1;
					end
				end
				default: bus_q <= BUS_IDLE;
			endcase
		end
	end

	assign sda_out = sda_out_q;
	assign sda_oe = sda_oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Threshold compare and sticky status
	logic ot_now;
	logic otw_now;
	logic utw_now;
	status_s status_q;
	logic alert_n_q;
	logic [1:0] mode;
	logic [2:0] retry;
	logic [2:0] delay;

	// Linear-format values compared as raw signed words; exponents assumed equal
	assign ot_now = $signed(temp_value) > $signed(ot_limit_q);
	assign otw_now = $signed(temp_value) > $signed(ot_warn_q);
	assign utw_now = $signed(temp_value) < $signed(ut_warn_q);
	assign mode = action_q[`ACT_MODE_HI:`ACT_MODE_LO];
	assign retry = action_q[`ACT_RETRY_HI:`ACT_RETRY_LO];
	assign delay = action_q[`ACT_DELAY_HI:`ACT_DELAY_LO];

	// Set wins over clear so an event in the clearing cycle is kept
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			status_q <= '0;
			alert_n_q <= 1'b1;
		end
		else
		begin
			status_q.ot_fault <= ot_now | (status_q.ot_fault & ~fault_clear); // see R6
			status_q.ot_warn <= otw_now | (status_q.ot_warn & ~fault_clear); // see R16
			status_q.ut_warn <= utw_now | (status_q.ut_warn & ~fault_clear); // see R16
			alert_n_q <= ~(|status_q); // see R6 R16
		end
	end

	assign status = status_q;
	assign alert_out_n = alert_n_q;
	assign limits = lim_q;

	fault_alert_a: assert property (ot_now |=> status.ot_fault ##1 !alert_out_n) // see R6
		else $error("fault did not set status and alert");
	warn_alert_a: assert property ((otw_now || utw_now) |=> // see R16
		(status.ot_warn || status.ut_warn) ##1 !alert_out_n)
		else $error("warning did not set status and alert");

	////////////////////////////////////////////////////////////////////////////////
	// Fault response sequencer
	ot_e ot_q;
	logic [2:0] retries_q;
	logic [2:0] units_q;
	logic [`TIMER_W-1:0] cyc_q;
	logic [`TIMER_W-1:0] unit_last;
	logic out_en_q;

	assign unit_last = (ot_q == OT_DELAY) ? `TIMER_W'(DELAY_UNIT_CYC - 1) :
		`TIMER_W'(RESTART_UNIT_CYC - 1); // see R15

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ot_q <= OT_RUN;
			retries_q <= `RETRY_NONE;
			units_q <= 3'h0;
			cyc_q <= '0;
		end
		else
		begin
			if (units_q != 3'h0 && cyc_q == unit_last)
			begin
				cyc_q <= '0;
				units_q <= units_q - 3'h1; // see R13
			end
			else if (units_q != 3'h0)
				cyc_q <= cyc_q + `TIMER_W'(1);
			case (ot_q)
				OT_RUN:
				begin
					if (ot_now && mode == `MODE_DELAY)
					begin
						ot_q <= OT_DELAY; // see R8
						units_q <= delay;
						cyc_q <= '0;
					end
					else if (ot_now && mode == `MODE_DISABLE)
					begin
						ot_q <= (retry == `RETRY_NONE) ? OT_LATCHED : OT_SPACE; // see R9 R11
						retries_q <= retry;
						units_q <= delay;
						cyc_q <= '0;
					end
					else if (ot_now && mode == `MODE_HOLD)
						ot_q <= OT_HOLD; // see R10
				end
				OT_DELAY:
				begin
					if (!ot_now)
						ot_q <= OT_RUN;
					else if (units_q == 3'h0)
					begin
						ot_q <= (retry == `RETRY_NONE) ? OT_LATCHED : OT_SPACE; // see R8
						retries_q <= retry;
						units_q <= delay;
						cyc_q <= '0;
					end
				end
				OT_SPACE:
				begin
					if (!enable_request || other_shutdown)
						ot_q <= OT_LATCHED; // see R14
					else if (units_q == 3'h0 && !ot_now)
						ot_q <= OT_RUN;
					else if (units_q == 3'h0 && retries_q == `RETRY_LAST)
						ot_q <= OT_LATCHED; // see R12
					else if (units_q == 3'h0)
					begin
						// Failed attempt: wait one more spacing before the next
						if (retries_q != `RETRY_FOREVER)
							retries_q <= retries_q - 3'h1; // see R12 R14
						units_q <= delay; // see R13
						cyc_q <= '0;
					end
				end
				OT_LATCHED:
				begin
					if (fault_clear)
						ot_q <= OT_RUN; // see R11 R12
				end
				OT_HOLD:
				begin
					if (!ot_now)
						ot_q <= OT_RUN; // see R10
				end
				default: ot_q <= OT_RUN;
			endcase
		end
	end

	// Mode 00 never leaves RUN, so regulation is untouched
	always_ff @(posedge clk)
	begin
		if (reset)
			out_en_q <= 1'b0;
		else
			out_en_q <= enable_request && (ot_q == OT_RUN || ot_q == OT_DELAY); // see R7 R8
	end

	assign output_enable = out_en_q;

	sequence ot_trip(logic [1:0] m);
		ot_q == OT_RUN && ot_now && mode == m;
	endsequence

	mode_ignore_a: assert property (ot_trip(`MODE_IGNORE) |=> ot_q == OT_RUN) // see R7
		else $error("ignore mode left run state");
	mode_delay_a: assert property (ot_trip(`MODE_DELAY) |=> ot_q == OT_DELAY) // see R8
		else $error("delay mode did not start delay");
	delay_end_a: assert property (ot_q == OT_DELAY && ot_now && units_q == 3'h0 // see R8
		|=> ot_q == OT_SPACE || ot_q == OT_LATCHED)
		else $error("delay end did not shut down");
	mode_disable_a: assert property (ot_trip(`MODE_DISABLE) |=> ##1 !output_enable) // see R9
		else $error("disable mode left output on");
	no_retry_a: assert property (ot_q == OT_RUN && ot_now && mode == `MODE_DISABLE && // see R11
		retry == `RETRY_NONE |=> ot_q == OT_LATCHED)
		else $error("zero retry did not latch off");
	hold_off_a: assert property (ot_trip(`MODE_HOLD) |=> ot_q == OT_HOLD ##1 !output_enable) // see R10
		else $error("hold mode left output on");
	hold_release_a: assert property (ot_q == OT_HOLD && !ot_now |=> ot_q == OT_RUN) // see R10
		else $error("hold mode did not release");
	retry_last_a: assert property (ot_q == OT_SPACE && units_q == 3'h0 && ot_now && // see R12
		retries_q == `RETRY_LAST && enable_request && !other_shutdown
		|=> ot_q == OT_LATCHED)
		else $error("last failed retry did not latch off");
	space_unit_a: assert property (ot_q == OT_SPACE && units_q != 3'h0 && // see R13 R15
		cyc_q == unit_last |=> cyc_q == '0 && units_q == $past(units_q) - 3'h1)
		else $error("restart spacing unit miscounted");
	retry_stop_a: assert property (ot_q == OT_SPACE && (!enable_request || other_shutdown) // see R14
		|=> ot_q == OT_LATCHED)
		else $error("retry did not stop on disable");

endmodule // fault_limit_response_unit

// ==== fault_limit_consts.svh ====
// Command codes, field positions, reset values and timing counts of the fault limit block
`ifndef FAULT_LIMIT_CONSTS_SVH
`define FAULT_LIMIT_CONSTS_SVH

// Management bus command codes
`define CMD_OC_LIMIT 8'h46
`define CMD_UC_LIMIT 8'h4B
`define CMD_OT_LIMIT 8'h4F
`define CMD_OT_ACTION 8'h50
`define CMD_OT_WARN 8'h51
`define CMD_UT_WARN 8'h52

// Fault action byte fields
`define ACT_MODE_HI 7
`define ACT_MODE_LO 6
`define ACT_RETRY_HI 5
`define ACT_RETRY_LO 3
`define ACT_DELAY_HI 2
`define ACT_DELAY_LO 0
`define MODE_IGNORE 2'h0
`define MODE_DELAY 2'h1
`define MODE_DISABLE 2'h2
`define MODE_HOLD 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7
`define RETRY_LAST 3'h1

// Reset values
`define RST_OC_LIMIT 16'h7FFF
`define RST_UC_LIMIT 16'h0000
`define RST_OT_LIMIT 16'h7FFF
`define RST_OT_WARN 16'h7FFF
`define RST_UT_WARN 16'h8000
`define RST_OT_ACTION 8'h80

// Timing
`define CLK_HZ 25000000
`define OT_DELAY_UNIT_MS 80
`define OT_RESTART_UNIT_MS 32
`define OT_DELAY_UNIT_CYC (`OT_DELAY_UNIT_MS * (`CLK_HZ / 1000))
`define OT_RESTART_UNIT_CYC (`OT_RESTART_UNIT_MS * (`CLK_HZ / 1000))
`define TIMER_W 24

// Bus framing
`define BUS_ADDR_DEFAULT 7'h20
`define BYTE_BITS 4'h8
`define BYTE_LAST_BIT 4'h7
`define IDX_ADDR 3'h0
`define IDX_CMD 3'h1
`define IDX_DATA_LO 3'h2
`define IDX_DATA_HI 3'h3
`define IDX_MAX 3'h7
`define WORD_WR_COUNT 3'h4
`define BYTE_WR_COUNT 3'h3
`define TX_FILL 8'hFF

`endif

// ==== fault_limit_pkg.sv ====
// Types shared by the fault limit block
package fault_limit_pkg;

	typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK, BUS_TX_LOAD} bus_e;

	typedef enum logic [2:0] {OT_RUN, OT_DELAY, OT_SPACE, OT_LATCHED, OT_HOLD} ot_e;

	typedef struct packed {
		logic ot_fault;
		logic ot_warn;
		logic ut_warn;
	} status_s;

	typedef struct packed {
		logic [15:0] oc;
		logic [15:0] uc;
	} limits_s;

endpackage

// ==== pmbus_host_model.sv ====
// Behavioural management bus host driving the register port of the fault limit block
module pmbus_host_model #(
	parameter logic [6:0] ADDR = 7'h20
) (
	// Clock
	input wire logic clk,
	// Bus pins
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;

	logic nack_seen;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		nack_seen = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quarter of a 320 ns bus period; SCL idles high between frames
	task automatic qtr;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic bit_out(input logic b);
		sda_low = ~b;
		qtr;
		scl = 1'b1;
		qtr;
		qtr;
		scl = 1'b0;
		qtr;
	endtask

	// Released line floats to its pull-up, so a silent device reads as 1
	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		qtr;
		scl = 1'b1;
		qtr;
		b = sda_line;
		qtr;
		scl = 1'b0;
		qtr;
	endtask

	// Serves as start and as repeated start
	task automatic start_c;
		sda_low = 1'b0;
		qtr;
		scl = 1'b1;
		qtr;
		sda_low = 1'b1;
		qtr;
		scl = 1'b0;
		qtr;
	endtask

	task automatic stop_c;
		sda_low = 1'b1;
		qtr;
		scl = 1'b1;
		qtr;
		sda_low = 1'b0;
		qtr;
	endtask

	task automatic send_byte(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
		bit_in(a);
		if (a)
			nack_seen = 1'b1;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bit_in(b[i]);
		bit_out(last);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] d);
		start_c;
		send_byte({ADDR, 1'b0});
		send_byte(cmd);
		send_byte(d[7:0]);
		send_byte(d[15:8]);
		stop_c;
	endtask

	task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d);
		start_c;
		send_byte({ADDR, 1'b0});
		send_byte(cmd);
		send_byte(d);
		stop_c;
	endtask

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
		start_c;
		send_byte({ADDR, 1'b0});
		send_byte(cmd);
		start_c;
		send_byte({ADDR, 1'b1});
		recv_byte(1'b0, d[7:0]);
		recv_byte(1'b1, d[15:8]);
		stop_c;
	endtask

	task automatic read_byte(input logic [7:0] cmd, output logic [7:0] d);
		start_c;
		send_byte({ADDR, 1'b0});
		send_byte(cmd);
		start_c;
		send_byte({ADDR, 1'b1});
		recv_byte(1'b1, d);
		stop_c;
	endtask
endmodule // pmbus_host_model

// ==== tb_top.sv ====
// Self-checking bench for the fault limit response unit
`include "fault_limit_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fault_limit_pkg::*;

	// Shortened units keep the timed responses to tens of cycles
	localparam int DU = 10;
	localparam int RU = 4;
	localparam logic [15:0] HOT = 16'h0120;
	localparam logic [15:0] MILD = 16'h0050;

	typedef struct packed {
		logic [7:0] cmd;
		logic word;
		logic [15:0] rst;
		logic [15:0] val;
	} row_s;

	logic clk = 1'b0;
	logic reset, scl, sda_low, sda_line, sda_out, sda_oe;
	logic enable_request, other_shutdown, fault_clear, output_enable, alert_out_n;
	logic [15:0] temp_value, v;
	status_s status;
	limits_s limits;
	int err_count = 0;
	int checks_done = 0;
	row_s rows [6];

	always #20 clk = ~clk;

	// Open-drain data line with pull-up
	assign sda_line = (sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

	fault_limit_response_unit #(.BUS_ADDR(7'h20), .DELAY_UNIT_CYC(DU), .RESTART_UNIT_CYC(RU)) dut_u (
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .temp_value(temp_value), .enable_request(enable_request),
		.other_shutdown(other_shutdown), .fault_clear(fault_clear),
		.output_enable(output_enable), .alert_out_n(alert_out_n), .status(status),
		.limits(limits)
	);

	pmbus_host_model #(.ADDR(7'h20)) host_u (
		.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_oe(input logic exp, input int max_cyc);
		for (int i = 0; i < max_cyc && output_enable !== exp; i++)
			tick(1);
		chk_bit("output_enable wait", exp, output_enable);
		if (output_enable !== exp)
			summarize();
	endtask

	task automatic pulse_clear;
		fault_clear = 1'b1;
		tick(1);
		fault_clear = 1'b0;
		tick(2);
	endtask

	task automatic cool_clear;
		temp_value = MILD;
		tick(3);
		pulse_clear();
		wait_oe(1'b1, 6);
	endtask

	task automatic set_act(input logic [7:0] a);
		host_u.write_byte(`CMD_OT_ACTION, a);
		tick(2);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset = 1'b1;
		temp_value = MILD;
		enable_request = 1'b1;
		other_shutdown = 1'b0;
		fault_clear = 1'b0;
		rows[0] = '{`CMD_OC_LIMIT, 1'b1, 16'h7FFF, 16'h1234};
		rows[1] = '{`CMD_UC_LIMIT, 1'b1, 16'h0000, 16'hA5C3};
		rows[2] = '{`CMD_OT_LIMIT, 1'b1, 16'h7FFF, 16'h0100};
		rows[3] = '{`CMD_OT_ACTION, 1'b0, 16'h0080, 16'h00C0};
		rows[4] = '{`CMD_OT_WARN, 1'b1, 16'h7FFF, 16'h00F0};
		rows[5] = '{`CMD_UT_WARN, 1'b1, 16'h8000, 16'h0010};
		tick(6);
		chk_bit("output_enable in reset", 1'b0, output_enable);
		chk_bit("alert_out_n in reset", 1'b1, alert_out_n);
		chk_word("status in reset", 16'h0000, {13'h0, status});
		chk_bit("sda_oe in reset", 1'b0, sda_oe);
		chk_bit("sda_out in reset", 1'b0, sda_out);
		reset = 1'b0;
		tick(4);
		chk_bit("output_enable after reset", 1'b1, output_enable);
		// Reset values, then write and read back each register
		for (int i = 0; i < 6; i++)
		begin
			v = 16'h0000;
			if (rows[i].word)
				host_u.read_word(rows[i].cmd, v);
			else
				host_u.read_byte(rows[i].cmd, v[7:0]);
			chk_word("register reset value", rows[i].rst, v);
			if (rows[i].word)
				host_u.write_word(rows[i].cmd, rows[i].val);
			else
				host_u.write_byte(rows[i].cmd, rows[i].val[7:0]);
			if (rows[i].word)
				host_u.read_word(rows[i].cmd, v);
			else
				host_u.read_byte(rows[i].cmd, v[7:0]);
			chk_word("register readback", rows[i].val, v);
		end
		chk_word("limits.oc", 16'h1234, limits.oc);
		chk_word("limits.uc", 16'hA5C3, limits.uc);
		// Short write to a word register is dropped; unknown command is refused
		host_u.write_byte(`CMD_OT_LIMIT, 8'h77);
		host_u.read_word(`CMD_OT_LIMIT, v);
		chk_word("short write dropped", 16'h0100, v);
		host_u.nack_seen = 1'b0;
		host_u.write_word(8'h47, 16'h5555);
		chk_bit("unmapped command nack", 1'b1, host_u.nack_seen);
		// Warnings alert without touching the output
		temp_value = 16'h00F8;
		tick(4);
		chk_bit("status.ot_warn", 1'b1, status.ot_warn);
		chk_bit("alert_out_n warn", 1'b0, alert_out_n);
		chk_bit("output_enable warn", 1'b1, output_enable);
		chk_bit("status.ot_fault warn", 1'b0, status.ot_fault);
		temp_value = 16'h0008;
		tick(4);
		chk_bit("status.ut_warn", 1'b1, status.ut_warn);
		cool_clear();
		chk_bit("alert_out_n cleared", 1'b1, alert_out_n);
		// Mode 00 keeps running
		set_act(8'h00);
		temp_value = HOT;
		tick(4);
		chk_bit("status.ot_fault", 1'b1, status.ot_fault);
		chk_bit("alert_out_n fault", 1'b0, alert_out_n);
		tick(20);
		chk_bit("output_enable ignore", 1'b1, output_enable);
		cool_clear();
		// Mode 11 follows the fault
		set_act(8'hC0);
		temp_value = HOT;
		wait_oe(1'b0, 4);
		tick(10);
		chk_bit("output_enable hold", 1'b0, output_enable);
		temp_value = MILD;
		wait_oe(1'b1, 5);
		cool_clear();
		// Mode 10 with no retry stays off until cleared
		set_act(8'h80);
		temp_value = HOT;
		wait_oe(1'b0, 4);
		temp_value = MILD;
		tick(20);
		chk_bit("output_enable no retry", 1'b0, output_enable);
		cool_clear();
		// Retry spacing of two restart units
		set_act(8'h92);
		temp_value = HOT;
		wait_oe(1'b0, 4);
		temp_value = MILD;
		tick(2);
		chk_bit("output_enable in spacing", 1'b0, output_enable);
		wait_oe(1'b1, 2 * RU);
		cool_clear();
		// Two failed attempts end in latched off
		set_act(8'h92);
		temp_value = HOT;
		tick(4 * RU + 8);
		temp_value = MILD;
		tick(20);
		chk_bit("output_enable retries spent", 1'b0, output_enable);
		cool_clear();
		// Endless retry recovers, but stops on another shutdown
		set_act(8'hBA);
		temp_value = HOT;
		tick(40);
		temp_value = MILD;
		wait_oe(1'b1, 3 * RU);
		temp_value = HOT;
		other_shutdown = 1'b1;
		tick(12);
		temp_value = MILD;
		other_shutdown = 1'b0;
		tick(20);
		chk_bit("output_enable retry stopped", 1'b0, output_enable);
		cool_clear();
		// Mode 01 runs three delay units before shutting down
		set_act(8'h43);
		temp_value = HOT;
		tick(3 * DU - 5);
		chk_bit("output_enable during delay", 1'b1, output_enable);
		wait_oe(1'b0, 10);
		temp_value = MILD;
		tick(10);
		chk_bit("output_enable after delay", 1'b0, output_enable);
		cool_clear();
		// Switching the output off also stops endless retry
		enable_request = 1'b0;
		tick(3);
		chk_bit("output_enable request off", 1'b0, output_enable);
		enable_request = 1'b1;
		tick(3);
		set_act(8'hBA);
		temp_value = HOT;
		wait_oe(1'b0, 4);
		enable_request = 1'b0;
		tick(4);
		enable_request = 1'b1;
		temp_value = MILD;
		tick(20);
		chk_bit("output_enable retry request off", 1'b0, output_enable);
		cool_clear();
		// Reset in mid-run clears status and registers
		temp_value = HOT;
		tick(4);
		chk_bit("alert_out_n before reset", 1'b0, alert_out_n);
		reset = 1'b1;
		tick(2);
		chk_bit("alert_out_n mid reset", 1'b1, alert_out_n);
		chk_bit("output_enable mid reset", 1'b0, output_enable);
		reset = 1'b0;
		tick(3);
		chk_word("status after reset", 16'h0000, {13'h0, status});
		chk_bit("output_enable after mid reset", 1'b1, output_enable);
		host_u.read_word(`CMD_OT_LIMIT, v);
		chk_word("ot limit after reset", `RST_OT_LIMIT, v);
		chk_word("limits.oc after reset", `RST_OC_LIMIT, limits.oc);
		temp_value = MILD;
		summarize();
	end
endmodule // tb_top
